// ---- inc/timer3_pkg.sv ----
// Constants and types for the timer 3 control/status block.
// Assumes an 8-bit special-function-register bus on the system clock.
package timer3_pkg;

    // =========================================================
    // Register location
    localparam logic [7:0] CTRL_SFR_ADDR = 8'h91;
    localparam logic [7:0] CTRL_SFR_PAGE = 8'h00;
    localparam logic [7:0] CTRL_RESET    = 8'h00;

    // =========================================================
    // Field positions in the control register
    localparam int HI_FLAG_BIT   = 7;
    localparam int LO_FLAG_BIT   = 6;
    localparam int LO_IRQ_EN_BIT = 5;
    localparam int CAP_EN_BIT    = 4;
    localparam int SPLIT_BIT     = 3;
    localparam int RUN_BIT       = 2;
    localparam int ALT_CLK_HI    = 1;
    localparam int ALT_CLK_LO    = 0;

    // =========================================================
    // Alternate clock field codes
    typedef enum logic [1:0] {
        ALT_SYSDIV12_TRIG_LFO = 2'b00,
        ALT_EXTDIV8_TRIG_EXT  = 2'b01,
        ALT_RESERVED          = 2'b10,
        ALT_LFO_TRIG_EXT      = 2'b11
    } alt_clk_t;

    // =========================================================
    // Register-side state of the top module
    typedef struct packed {
        logic       lo_irq_en;
        logic       cap_en;
        logic       split;
        logic       run;
        alt_clk_t   alt_clk;
        logic [7:0] rdata;
        logic       irq;
    } ctrl_state_t;

    localparam ctrl_state_t CTRL_STATE_RESET = '{
        lo_irq_en: 1'h0,
        cap_en:    1'h0,
        split:     1'h0,
        run:       1'h0,
        alt_clk:   ALT_SYSDIV12_TRIG_LFO,
        rdata:     8'h00,
        irq:       1'h0
    };

    // State of one overflow flag
    typedef struct packed {
        logic flag;
    } flag_state_t;

    localparam flag_state_t FLAG_STATE_RESET = '{flag: 1'h0};

endpackage

// ---- inc/flag_if.sv ----
// Interface between the control logic and one overflow flag.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface flag_if;
    logic set;
    logic wr;
    logic wval;
    logic flag;

    // Control logic drives events and writes, reads the flag
    modport owner (output set, output wr, output wval, input flag);
    // Flag holder
    modport holder (input set, input wr, input wval, output flag);
endinterface

// ---- src/ovf_flag.sv ----
// One sticky overflow flag, set by hardware, written by software.
// Assumes set, wr and wval come from logic on the same clock.
`timescale 1ns/1ps
module ovf_flag (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Flag events and value
    flag_if.holder    fl
);

    timer3_pkg::flag_state_t st_ff;
    timer3_pkg::flag_state_t nxt_st;

    // =========================================================
    // Next flag value
    // Write stores the bit, but a same-cycle event always wins
    always_comb begin
        nxt_st = st_ff;
        if (fl.wr) begin
            nxt_st.flag = fl.wval;
        end
        if (fl.set) begin
            nxt_st.flag = 1'h1;
        end
    end

    // =========================================================
    // State register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_ff <= timer3_pkg::FLAG_STATE_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // No hardware path clears the flag
    assign fl.flag = st_ff.flag;

endmodule

// ---- src/timer3_control_status.sv ----
// Control and status register for timer 3: overflow flags, interrupt
// request, mode select, run gating and clock/trigger selection.
// Assumes the counter datapath sits beside it on the same system clock
// and reports wraps and capture triggers as one-cycle strobes.
`timescale 1ns/1ps
module timer3_control_status (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,

    // Special-function-register bus
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_page,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output      logic [7:0] sfr_rdata,

    // Global timer interrupt enable from the interrupt controller
    input  wire logic       timer_irq_enable,

    // Events from the counter datapath
    input  wire logic       count_high_byte_wrap,
    input  wire logic       count_low_byte_wrap,
    input  wire logic       count_word_wrap,
    input  wire logic       capture_event,

    // Control towards the counter datapath
    output      logic       split_mode_select,
    output      logic       run_control,
    output      logic       capture_mode_enable,
    output      logic       count_high_enable,
    output      logic       count_low_enable,
    output      logic       low_carry_to_high,

    // Reload and capture strobes
    output      logic       reload_word,
    output      logic       reload_high_byte,
    output      logic       reload_low_byte,
    output      logic       capture_load,

    // Alternate clock and capture trigger selection
    output      logic       alt_clk_sysdiv12,
    output      logic       alt_clk_ext_div8,
    output      logic       alt_clk_lfo,
    output      logic       trig_lfo,
    output      logic       trig_ext_div8,

    // Interrupt request to the processor
    output      logic       timer_irq
);

    // =========================================================
    // State and local signals
    timer3_pkg::ctrl_state_t st_ff;
    timer3_pkg::ctrl_state_t nxt_st;

    logic       ctrl_hit;
    logic       ctrl_wr;
    logic       ctrl_rd;
    logic       high_set;
    logic       low_set;
    logic       high_flag;
    logic       low_flag;
    logic [7:0] reg_view;

    flag_if hi_fl ();
    flag_if lo_fl ();

    // =========================================================
    // Address decode
    // Only page 0 maps the register; other pages see nothing here
    assign ctrl_hit = (sfr_addr == timer3_pkg::CTRL_SFR_ADDR)
                   && (sfr_page == timer3_pkg::CTRL_SFR_PAGE);
    assign ctrl_wr  = ctrl_hit && sfr_wr;
    assign ctrl_rd  = ctrl_hit && sfr_rd;

    // =========================================================
    // Overflow event sources
    // Split mode: the high flag follows the high byte on its own
    // 16-bit mode: of the wraps, only the full word wrap counts for the high flag
    // Capture mode, 16-bit only: every capture trigger also raises the high flag
    always_comb begin
        high_set = 1'h0;
        if (st_ff.split) begin
            high_set = count_high_byte_wrap;
        end else begin
            high_set = count_word_wrap;
        end
        if (st_ff.cap_en && !st_ff.split && capture_event) begin
            high_set = 1'h1;
        end
    end

    // Low byte wrap counts in either mode
    assign low_set = count_low_byte_wrap;

    // =========================================================
    // Flag holders
    // Each flag sees the whole-register write so a read-modify-write
    // by software leaves a flag untouched unless it writes 0 to it
    assign hi_fl.set  = high_set;
    assign hi_fl.wr   = ctrl_wr;
    assign hi_fl.wval = sfr_wdata[timer3_pkg::HI_FLAG_BIT];

    assign lo_fl.set  = low_set;
    assign lo_fl.wr   = ctrl_wr;
    assign lo_fl.wval = sfr_wdata[timer3_pkg::LO_FLAG_BIT];

    ovf_flag u_high_flag (
        .clk  (clk),
        .nrst (nrst),
        .fl   (hi_fl.holder)
    );

    ovf_flag u_low_flag (
        .clk  (clk),
        .nrst (nrst),
        .fl   (lo_fl.holder)
    );

    assign high_flag = hi_fl.flag;
    assign low_flag  = lo_fl.flag;

    // =========================================================
    // Register image as software reads it
    always_comb begin
        reg_view                           = timer3_pkg::CTRL_RESET;
        reg_view[timer3_pkg::HI_FLAG_BIT]   = high_flag;
        reg_view[timer3_pkg::LO_FLAG_BIT]   = low_flag;
        reg_view[timer3_pkg::LO_IRQ_EN_BIT] = st_ff.lo_irq_en;
        reg_view[timer3_pkg::CAP_EN_BIT]    = st_ff.cap_en;
        reg_view[timer3_pkg::SPLIT_BIT]     = st_ff.split;
        reg_view[timer3_pkg::RUN_BIT]       = st_ff.run;
        reg_view[timer3_pkg::ALT_CLK_HI]    = st_ff.alt_clk[1];
        reg_view[timer3_pkg::ALT_CLK_LO]    = st_ff.alt_clk[0];
    end

    // =========================================================
    // Next state: control bits, read data, interrupt request
    always_comb begin
        nxt_st = st_ff;

        // Every control bit is plain read/write
        if (ctrl_wr) begin
            nxt_st.lo_irq_en = sfr_wdata[timer3_pkg::LO_IRQ_EN_BIT];
            nxt_st.cap_en    = sfr_wdata[timer3_pkg::CAP_EN_BIT];
            nxt_st.split     = sfr_wdata[timer3_pkg::SPLIT_BIT];
            nxt_st.run       = sfr_wdata[timer3_pkg::RUN_BIT];
            nxt_st.alt_clk   = timer3_pkg::alt_clk_t'(
                sfr_wdata[timer3_pkg::ALT_CLK_HI:timer3_pkg::ALT_CLK_LO]);
        end

        // Read data is captured one cycle after the strobe; zero otherwise
        // so an idle bus never shows stale register contents
        if (ctrl_rd) begin
            nxt_st.rdata = reg_view;
        end else begin
            nxt_st.rdata = 8'h00;
        end

        // With the global enable, high flag always requests; low flag only with its own enable.
        // Registered so the request is glitch-free, at one cycle of lag.
        nxt_st.irq = timer_irq_enable
                  && (high_flag
                      || (low_flag && st_ff.lo_irq_en));
    end

    // =========================================================
    // State register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_ff <= timer3_pkg::CTRL_STATE_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // =========================================================
    // Bus read data and interrupt request
    assign sfr_rdata = st_ff.rdata;
    assign timer_irq = st_ff.irq;

    // =========================================================
    // Mode and run control towards the counter
    // 16-bit mode: low byte carries into the high byte, both gated by run
    // Split mode: the low byte free-runs, run gates the high byte only
    assign split_mode_select   = st_ff.split;
    assign run_control         = st_ff.run;
    assign capture_mode_enable = st_ff.cap_en;
    assign count_high_enable   = st_ff.run;
    assign count_low_enable    = st_ff.split || st_ff.run;
    assign low_carry_to_high   = !st_ff.split;

    // =========================================================
    // Reload and capture strobes
    // Capture mode replaces the 16-bit reload with a capture load;
    // capture is only meaningful with the full 16-bit counter
    assign reload_word      = !st_ff.split && !st_ff.cap_en
                           && count_word_wrap;
    assign reload_high_byte = st_ff.split && count_high_byte_wrap;
    assign reload_low_byte  = st_ff.split && count_low_byte_wrap;
    assign capture_load     = st_ff.cap_en && !st_ff.split
                           && capture_event;

    // =========================================================
    // Alternate clock and trigger decode
    // The reserved code selects no source, so the counter stalls
    // on its alternate clock rather than running on a guess
    always_comb begin
        alt_clk_sysdiv12 = 1'h0;
        alt_clk_ext_div8 = 1'h0;
        alt_clk_lfo      = 1'h0;
        trig_lfo         = 1'h0;
        trig_ext_div8    = 1'h0;
        case (st_ff.alt_clk)
            timer3_pkg::ALT_SYSDIV12_TRIG_LFO: begin
                alt_clk_sysdiv12 = 1'h1;
                trig_lfo         = 1'h1;
            end
            timer3_pkg::ALT_EXTDIV8_TRIG_EXT: begin
                alt_clk_ext_div8 = 1'h1;
                trig_ext_div8    = 1'h1;
            end
            timer3_pkg::ALT_LFO_TRIG_EXT: begin
                alt_clk_lfo      = 1'h1;
                trig_ext_div8    = 1'h1;
            end
            default: begin
                alt_clk_sysdiv12 = 1'h0;
            end
        endcase
    end

endmodule

// ---- test/timer3_props.sv ----
// Concurrent checks for the timer 3 control/status block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module timer3_props (
    // Clock and reset
    input wire logic       clk,
    input wire logic       nrst,
    // Register bus
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_page,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // Events and controls
    input wire logic       timer_irq_enable,
    input wire logic       count_word_wrap,
    input wire logic       capture_event,
    input wire logic       split_mode_select,
    input wire logic       run_control,
    input wire logic       capture_mode_enable,
    input wire logic       count_high_enable,
    input wire logic       count_low_enable,
    input wire logic       low_carry_to_high,
    input wire logic       reload_word,
    input wire logic       capture_load,
    input wire logic       timer_irq
);
    // ==========================================================
    // Register hit decode and defaults
    logic hit;
    assign hit = (sfr_addr == 8'h91) && (sfr_page == 8'h00);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ==========================================================
    // Bus, mode and interrupt relations
    a_rdata_idle: assert property (!$past(sfr_rd && hit) |-> sfr_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_split_write: assert property (sfr_wr && hit |=> split_mode_select == $past(sfr_wdata[3]))
        else $error("split select did not follow write");
    a_run_cap_write: assert property (sfr_wr && hit |=>
        run_control == $past(sfr_wdata[2]) && capture_mode_enable == $past(sfr_wdata[4]))
        else $error("run or capture bit did not follow write");
    a_count_gating: assert property (count_high_enable == run_control &&
        count_low_enable == (split_mode_select || run_control) &&
        low_carry_to_high == !split_mode_select) else $error("count gating wrong");
    a_reload_word: assert property (reload_word ==
        (count_word_wrap && !split_mode_select && !capture_mode_enable))
        else $error("word reload strobe wrong");
    a_capture_load: assert property (capture_load ==
        (capture_event && capture_mode_enable && !split_mode_select))
        else $error("capture load strobe wrong");
    a_irq_word: assert property (!split_mode_select && count_word_wrap && timer_irq_enable
        ##1 timer_irq_enable |=> timer_irq) else $error("no irq after word wrap");
    a_irq_gate: assert property (!timer_irq_enable |=> !timer_irq)
        else $error("irq raised while disabled");
    a_flag_sticky: assert property (timer_irq && timer_irq_enable && !$past(sfr_wr && hit)
        |=> timer_irq) else $error("irq dropped without a write");
endmodule

// ---- test/testbench.sv ----
// Self-checking testbench for the timer 3 control/status block.
// Assumes the checker file is compiled before this one.
`timescale 1ns/1ps
module testbench;
    // ==========================================================
    // Stimulus, model and observed outputs
    logic       clk, nrst, sfr_wr, sfr_rd, en, hb, lb, ww, cap;
    logic [7:0] addr, page, wd, rdata, r;
    logic       split, run, cme, che, cle, lcth, rw, rh, rl, cl;
    logic       a12, a8, alfo, tlfo, text, irq;
    int         mismatches, n_checks;
    integer     seed = 84749;

    timer3_control_status timer3_control_status_inst (
        .clk(clk), .nrst(nrst), .sfr_addr(addr), .sfr_page(page), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(wd), .sfr_rdata(rdata), .timer_irq_enable(en),
        .count_high_byte_wrap(hb), .count_low_byte_wrap(lb), .count_word_wrap(ww),
        .capture_event(cap), .split_mode_select(split), .run_control(run),
        .capture_mode_enable(cme), .count_high_enable(che), .count_low_enable(cle),
        .low_carry_to_high(lcth), .reload_word(rw), .reload_high_byte(rh),
        .reload_low_byte(rl), .capture_load(cl), .alt_clk_sysdiv12(a12),
        .alt_clk_ext_div8(a8), .alt_clk_lfo(alfo), .trig_lfo(tlfo),
        .trig_ext_div8(text), .timer_irq(irq));

    // Clock, 5 ns period
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    // ==========================================================
    // Expectation helpers
    function automatic logic [5:0] ctl_exp(input logic [7:0] v);
        return {v[3], v[2], v[4], v[2], v[3] | v[2], ~v[3]};
    endfunction
    function automatic logic [4:0] alt_exp(input logic [1:0] c);
        case (c)
            2'h0: return 5'h12;
            2'h1: return 5'h09;
            2'h3: return 5'h05;
            default: return 5'h00;
        endcase
    endfunction

    // ==========================================================
    // Bus and event tasks, all entered at a falling edge
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        sfr_wr = 1'h1;
        wd = d;
        @(negedge clk);
        sfr_wr = 1'h0;
        if (addr == 8'h91 && page == 8'h00) r = d;
    endtask
    task automatic rd();
        sfr_rd = 1'h1;
        @(negedge clk);
        sfr_rd = 1'h0;
        chk(rdata, (addr == 8'h91 && page == 8'h00) ? r : 8'h00);
        chk(8'({split, run, cme, che, cle, lcth}), 8'(ctl_exp(r)));
        chk(8'({a12, a8, alfo, tlfo, text}), 8'(alt_exp(r[1:0])));
        chk(8'(irq), 8'(en & (r[7] | (r[6] & r[5]))));
    endtask
    task automatic ev(input logic [3:0] m);
        {hb, lb, ww, cap} = m;
        #1;
        chk(8'({rw, rh, rl, cl}),
            8'({~r[3] & ~r[4] & ww, r[3] & hb, r[3] & lb, r[4] & ~r[3] & cap}));
        @(negedge clk);
        if (r[3] ? hb : (ww | (cap & r[4]))) r[7] = 1'h1;
        if (lb) r[6] = 1'h1;
        {hb, lb, ww, cap} = 4'h0;
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watchdog, well beyond the expected run of about 660 cycles
    initial begin
        #20000;
        mismatches++;
        close_out();
    end

    // ==========================================================
    // Corner cases, then random traffic
    initial begin
        {nrst, sfr_wr, sfr_rd, en, hb, lb, ww, cap} = 8'h00;
        addr = 8'h91;
        page = 8'h00;
        wd = 8'h00;
        r = 8'h00;
        repeat (6) @(negedge clk);
        nrst = 1'h1;
        rd();
        for (int i = 0; i < 4; i++) begin
            wr(8'(i));
            rd();
        end
        // Wrong address and wrong page are ignored
        addr = 8'h92;
        wr(8'hFF);
        rd();
        addr = 8'h91;
        page = 8'h01;
        wr(8'hFF);
        rd();
        page = 8'h00;
        @(negedge clk); // Idle edge between back-to-back reads
        rd();
        // Split flags, low irq enable, disable, long hold
        en = 1'h1;
        wr(8'h08);
        ev(4'h8);
        rd();
        wr(8'h28);
        ev(4'h4);
        rd();
        en = 1'h0;
        @(negedge clk); // Idle edge between back-to-back reads
        rd();
        repeat (20) @(negedge clk);
        rd();
        // Word wrap colliding with a clearing write
        wr(8'h00);
        // Let an edge pass so the write strobe is not re-raised in one step
        @(negedge clk);
        ww = 1'h1;
        sfr_wr = 1'h1;
        @(negedge clk);
        {ww, sfr_wr} = 2'h0;
        r[7] = 1'h1;
        rd();
        wr(8'h10);
        ev(4'h1);
        rd();
        // Random writes and events; only the kept flags may show
        for (int i = 0; i < 300; i++) begin
            en = 1'($random(seed));
            if ($random(seed) & 1) wr(8'($random(seed)));
            else ev(4'($random(seed)));
            rd();
        end
        close_out();
    end
endmodule

bind timer3_control_status timer3_props timer3_props_inst (
    .clk(clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .timer_irq_enable(timer_irq_enable), .count_word_wrap(count_word_wrap),
    .capture_event(capture_event), .split_mode_select(split_mode_select),
    .run_control(run_control), .capture_mode_enable(capture_mode_enable),
    .count_high_enable(count_high_enable), .count_low_enable(count_low_enable),
    .low_carry_to_high(low_carry_to_high), .reload_word(reload_word),
    .capture_load(capture_load), .timer_irq(timer_irq));
